// file: rtl/adcr_top.sv
// Converter control register bank with AXI4-Lite slave
`timescale 1ns/10ps
// How it works
// - Byte, halfword and word writes complete atomically on every register; reads at an address not word aligned return zero.
// - Each byte lane of a register is written on its own strobe.
// - Write guard input high makes every register ignore writes.
// - Enable-protected fields keep their value while the converter is enabled.
// - Reserved bits read zero; software writes zero there.
// - First control register resets to zero; standby run, enable, software reset bits.
// - Standby run clear halts the converter during standby sleep.
// - Enable reads back at once, sets busy; takes effect after synchronization.
// - Software reset returns all registers to reset and disables the converter.
// - A write setting software reset discards all its other bits.
// - Software reset reads one until the reset finishes; busy reads one until the sync ends, one cycle earlier.
// - Reference register resets zero; bit 7 enables buffer offset compensation.
// - Reference select picks one of five references; codes 5 to 15 reserved.
// - Adjust field divides the accumulated sum by two to its value.
// - Sample count codes 0 to 10 accumulate 1 to 1024 samples.
// - Sampling phase lasts field plus one half converter clock periods.
// - Second control register resets zero, write-synchronized, fields as laid out.
// - A sync write while busy stalls the bus until the sync ends.
// - Prescaler divides the peripheral clock by 4 up to 512.
module adcr_top
  import adcr_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic peripheral_write_guard,
  input wire logic standby_sleep,
  output logic converter_enabled,
  output logic converter_running,
  output logic converter_tick,
  output logic sync_busy_flag,
  output logic ref_buffer_offset_comp,
  output logic [3:0] reference_select,
  output logic reference_select_valid,
  output logic [2:0] accumulate_divide_shift,
  output logic [10:0] sample_total,
  output logic sample_count_valid,
  output logic [6:0] sampling_half_periods,
  output logic [2:0] prescaler,
  output logic [1:0] resolution_select,
  output logic gain_offset_correction_on,
  output logic continuous_conversion,
  output logic result_left_align,
  output logic differential_input
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [7:0] control_first;
  logic [7:0] reference_control;
  logic [7:0] averaging_control;
  logic [7:0] sampling_time_control;
  logic [15:0] control_second;
  logic [15:0] control_second_active;
  logic converter_on;

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  logic [5:0] w_index;
  logic write_allowed;
  logic first_byte;
  logic software_reset_bit_write;
  logic enable_change;
  logic second_write;
  logic needs_sync;
  logic stall;
  logic commit;
  logic software_reset_bit_done;
  logic enable_locked;

  adcr_sync_if sync_bus();

  adcr_conv_domain u_domain (
    .clock(clock),
    .rstn(rstn),
    .link(sync_bus.dom)
  );

  always_comb begin
    w_index = aw_addr[7:2];
    write_allowed = !peripheral_write_guard;
    enable_locked = control_first[CF_ENABLE] | converter_on;
    first_byte = (w_index == IDX_CONTROL_FIRST) && w_strb[0] && write_allowed;
    software_reset_bit_write = first_byte && w_data[CF_SOFTWARE_RESET_BIT];
    enable_change = first_byte && (w_data[CF_ENABLE] != control_first[CF_ENABLE]);
    second_write = (w_index == IDX_CONTROL_SECOND) && (|w_strb[1:0]) && write_allowed
                   && !enable_locked;
    needs_sync = software_reset_bit_write || enable_change || second_write;
    stall = sync_bus.busy && needs_sync;
    commit = aw_held && w_held && !s_axi_bvalid && !stall;
  end

  assign software_reset_bit_done = sync_bus.done && control_first[CF_SOFTWARE_RESET_BIT];
  assign sync_bus.req = commit && needs_sync;
  assign sync_bus.prescaler = control_second_active[CS_PRESC_LSB +: 3];

  // ------------------------------------------------------------
  // Write channels, address and data in either order
  // ------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_bresp = RESP_OKAY;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (commit) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (commit) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // First control register
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      control_first <= BYTE_RESET;
    end else if (software_reset_bit_done) begin
      control_first <= BYTE_RESET;
    end else if (commit && software_reset_bit_write) begin
      control_first <= control_first | CONTROL_FIRST_SOFTWARE_RESET_BIT;
    end else if (commit && first_byte) begin
      control_first <= (w_data[7:0] & CONTROL_FIRST_MASK) | (control_first & CONTROL_FIRST_SOFTWARE_RESET_BIT);
    end
  end

  // ------------------------------------------------------------
  // Reference, averaging and sampling registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reference_control <= BYTE_RESET;
    end else if (software_reset_bit_done) begin
      reference_control <= BYTE_RESET;
    end else if (commit && write_allowed && w_strb[0] && w_index == IDX_REFERENCE) begin
      reference_control <= w_data[7:0] & REFERENCE_MASK;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      averaging_control <= BYTE_RESET;
    end else if (software_reset_bit_done) begin
      averaging_control <= BYTE_RESET;
    end else if (commit && write_allowed && w_strb[0] && w_index == IDX_AVERAGING) begin
      averaging_control <= w_data[7:0] & AVERAGING_MASK;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sampling_time_control <= BYTE_RESET;
    end else if (software_reset_bit_done) begin
      sampling_time_control <= BYTE_RESET;
    end else if (commit && write_allowed && w_strb[0] && w_index == IDX_SAMPLING) begin
      sampling_time_control <= w_data[7:0] & SAMPLING_MASK;
    end
  end

  // ------------------------------------------------------------
  // Second control register, written copy and synchronized copy
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      control_second <= HALF_RESET;
    end else if (software_reset_bit_done) begin
      control_second <= HALF_RESET;
    end else if (commit && second_write) begin
      control_second <= lane_merge(control_second, w_data[15:0], w_strb[1:0], CONTROL_SECOND_MASK);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      control_second_active <= HALF_RESET;
      converter_on <= 1'b0;
    end else if (software_reset_bit_done) begin
      control_second_active <= HALF_RESET;
      converter_on <= 1'b0;
    end else if (sync_bus.done) begin
      control_second_active <= control_second;
      converter_on <= control_first[CF_ENABLE];
    end
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  logic [31:0] read_word;
  logic [5:0] r_index;

  always_comb begin
    r_index = s_axi_araddr[7:2];
    read_word = 32'h00000000;
    case (r_index)
      IDX_CONTROL_FIRST: read_word = {24'h000000, control_first};
      IDX_REFERENCE: read_word = {24'h000000, reference_control};
      IDX_AVERAGING: read_word = {24'h000000, averaging_control};
      IDX_SAMPLING: read_word = {24'h000000, sampling_time_control};
      IDX_CONTROL_SECOND: read_word = {16'h0000, control_second};
      IDX_STATUS: read_word = {24'h000000, sync_bus.busy, 7'h00};
      default: read_word = 32'h00000000;
    endcase
    if (s_axi_araddr[1:0] != 2'h0) begin
      read_word = 32'h00000000;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = RESP_OKAY;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Converter facing outputs
  // ------------------------------------------------------------
  assign converter_tick = sync_bus.tick && converter_running;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      converter_enabled <= 1'b0;
      converter_running <= 1'b0;
      sync_busy_flag <= 1'b0;
    end else begin
      converter_enabled <= converter_on;
      converter_running <= converter_on && (!standby_sleep || control_first[CF_STANDBY_RUN]);
      sync_busy_flag <= sync_bus.busy || sync_bus.req;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ref_buffer_offset_comp <= 1'b0;
      reference_select <= 4'h0;
      reference_select_valid <= 1'b1;
    end else begin
      ref_buffer_offset_comp <= reference_control[RC_COMP];
      reference_select <= reference_control[3:0];
      reference_select_valid <= reference_control[3:0] <= REF_SELECT_LAST;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      accumulate_divide_shift <= 3'h0;
      sample_total <= 11'h001;
      sample_count_valid <= 1'b1;
      sampling_half_periods <= 7'h01;
    end else begin
      accumulate_divide_shift <= averaging_control[AV_ADJ_LSB +: 3];
      if (averaging_control[3:0] <= SAMPLE_CODE_LAST) begin
        sample_total <= 11'h001 << averaging_control[3:0];
        sample_count_valid <= 1'b1;
      end else begin
        sample_total <= 11'h000;
        sample_count_valid <= 1'b0;
      end
      sampling_half_periods <= {1'b0, sampling_time_control[5:0]} + 7'h01;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prescaler <= 3'h0;
      resolution_select <= 2'h0;
      gain_offset_correction_on <= 1'b0;
      continuous_conversion <= 1'b0;
      result_left_align <= 1'b0;
      differential_input <= 1'b0;
    end else begin
      prescaler <= control_second_active[CS_PRESC_LSB +: 3];
      resolution_select <= control_second_active[CS_RES_LSB +: 2];
      gain_offset_correction_on <= control_second_active[CS_CORR];
      continuous_conversion <= control_second_active[CS_FREE];
      result_left_align <= control_second_active[CS_LEFT];
      differential_input <= control_second_active[CS_DIFF];
    end
  end
endmodule

// file: common/adcr_pkg.sv
// Constants and helpers shared by the converter control register bank
package adcr_pkg;
  // ------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_CONTROL_FIRST = 6'h00;
  localparam logic [5:0] IDX_REFERENCE = 6'h01;
  localparam logic [5:0] IDX_AVERAGING = 6'h02;
  localparam logic [5:0] IDX_SAMPLING = 6'h03;
  localparam logic [5:0] IDX_CONTROL_SECOND = 6'h04;
  localparam logic [5:0] IDX_STATUS = 6'h19;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CF_SOFTWARE_RESET_BIT = 0;
  localparam int CF_ENABLE = 1;
  localparam int CF_STANDBY_RUN = 2;
  localparam int RC_COMP = 7;
  localparam int AV_ADJ_LSB = 4;
  localparam int CS_PRESC_LSB = 8;
  localparam int CS_RES_LSB = 4;
  localparam int CS_CORR = 3;
  localparam int CS_FREE = 2;
  localparam int CS_LEFT = 1;
  localparam int CS_DIFF = 0;
  localparam int ST_BUSY = 7;
  // ------------------------------------------------------------
  // Writable masks and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CONTROL_FIRST_MASK = 8'h06;
  localparam logic [7:0] CONTROL_FIRST_SOFTWARE_RESET_BIT = 8'h01;
  localparam logic [7:0] REFERENCE_MASK = 8'h8F;
  localparam logic [7:0] AVERAGING_MASK = 8'h7F;
  localparam logic [7:0] SAMPLING_MASK = 8'h3F;
  localparam logic [15:0] CONTROL_SECOND_MASK = 16'h073F;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] HALF_RESET = 16'h0000;
  localparam logic [3:0] REF_SELECT_LAST = 4'h4;
  localparam logic [3:0] SAMPLE_CODE_LAST = 4'hA;
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;

  function automatic logic [9:0] divider_last(input logic [2:0] code);
    divider_last = (10'h004 << code) - 10'h001;
  endfunction

  function automatic logic [15:0] lane_merge(input logic [15:0] old_value, input logic [15:0] new_value,
                                             input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] merged;
    merged = old_value;
    if (strb[0]) begin
      merged[7:0] = new_value[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = new_value[15:8];
    end
    lane_merge = merged & mask;
  endfunction
endpackage

// file: common/adcr_sync_if.sv
// Handshake between register bank and converter clock divider
`timescale 1ns/10ps
interface adcr_sync_if;
  logic req;
  logic [2:0] prescaler;
  logic tick;
  logic busy;
  logic done;
  modport ctrl(output req, output prescaler, input tick, input busy, input done);
  modport dom(input req, input prescaler, output tick, output busy, output done);
endinterface

// file: rtl/adcr_conv_domain.sv
// Converter clock divider and synchronization sequencer
`timescale 1ns/10ps
module adcr_conv_domain
  import adcr_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  adcr_sync_if.dom link
);
  logic [9:0] div_count;
  logic [1:0] tick_count;
  logic tick_now;
  logic busy;

  // ------------------------------------------------------------
  // Divider, one enable pulse per converter period
  // ------------------------------------------------------------
  assign tick_now = div_count >= divider_last(link.prescaler);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_count <= 10'h000;
    end else if (tick_now) begin
      div_count <= 10'h000;
    end else begin
      div_count <= div_count + 10'h001;
    end
  end

  // ------------------------------------------------------------
  // Sequencer, busy for a fixed number of converter ticks
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      tick_count <= 2'h0;
      link.done <= 1'b0;
    end else begin
      link.done <= 1'b0;
      if (link.req && !busy) begin
        busy <= 1'b1;
        tick_count <= 2'h0;
      end else if (busy && tick_now) begin
        if (tick_count == SYNC_TICKS - 2'h1) begin
          busy <= 1'b0;
          link.done <= 1'b1;
        end else begin
          tick_count <= tick_count + 2'h1;
        end
      end
    end
  end

  assign link.tick = tick_now;
  assign link.busy = busy;
endmodule

// file: verification/adcr_props.sv
// Checker for bus handshakes and configuration outputs of the register bank
`timescale 1ns/10ps
module adcr_props
  import adcr_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic converter_running,
  input wire logic converter_tick,
  input wire logic [3:0] reference_select,
  input wire logic reference_select_valid,
  input wire logic [10:0] sample_total,
  input wire logic sample_count_valid,
  input wire logic [6:0] sampling_half_periods
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_bresp_okay; s_axi_bvalid |-> s_axi_bresp == RESP_OKAY; endproperty
  a_bresp_okay: assert property (p_bresp_okay) else $error("bad write response");
  property p_write_refused; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_write_refused: assert property (p_write_refused) else $error("write taken during response");
  property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
  property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_rdata_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_reserved_zero; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("upper read bits set");
  property p_ref_valid; reference_select_valid == (reference_select <= REF_SELECT_LAST); endproperty
  a_ref_valid: assert property (p_ref_valid) else $error("reference flag wrong");
  property p_sample_total; sample_count_valid ? $onehot(sample_total) : sample_total == 11'h000; endproperty
  a_sample_total: assert property (p_sample_total) else $error("sample total wrong");
  property p_half_periods; sampling_half_periods != 7'h00 && sampling_half_periods <= 7'h40; endproperty
  a_half_periods: assert property (p_half_periods) else $error("sampling length out of range");
  property p_tick_gated; converter_tick |-> converter_running; endproperty
  a_tick_gated: assert property (p_tick_gated) else $error("tick while halted");
endmodule
bind adcr_top adcr_props u_props (.clock, .rstn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .converter_running, .converter_tick, .reference_select, .reference_select_valid, .sample_total,
  .sample_count_valid, .sampling_half_periods);

// file: verification/adcr_tb_top.sv
// Self-checking bench for the converter control register bank
`timescale 1ns/10ps
module adcr_tb_top
  import adcr_pkg::*;
;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic peripheral_write_guard = 1'h0;
  logic standby_sleep = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resolution_select;
  logic [31:0] s_axi_rdata;
  logic converter_enabled, converter_running, converter_tick, sync_busy_flag, ref_buffer_offset_comp;
  logic reference_select_valid, sample_count_valid, gain_offset_correction_on, continuous_conversion;
  logic result_left_align, differential_input;
  logic [3:0] reference_select;
  logic [2:0] accumulate_divide_shift, prescaler;
  logic [10:0] sample_total;
  logic [6:0] sampling_half_periods;
  int err_count = 0;
  int checks = 0;
  logic [31:0] exp_q[$];
  logic [7:0] v;
  logic [7:0] rv;
  logic [7:0] addrs[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h64, 8'h14, 8'h80};
  int n;

  adcr_top dut (.clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .peripheral_write_guard,
    .standby_sleep, .converter_enabled, .converter_running, .converter_tick, .sync_busy_flag,
    .ref_buffer_offset_comp, .reference_select, .reference_select_valid, .accumulate_divide_shift,
    .sample_total, .sample_count_valid, .sampling_half_periods, .prescaler, .resolution_select,
    .gain_offset_correction_on, .continuous_conversion, .result_left_align, .differential_input);

  always #2 clock = ~clock;

  // ------------------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(ta && tw)) begin
      @(negedge clock);
      if (s_axi_awvalid && s_axi_awready) ta = 1'h1;
      if (s_axi_wvalid && s_axi_wready) tw = 1'h1;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    repeat ($urandom_range(0, 1)) @(posedge clock);
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clock);
      ta = s_axi_bvalid;
      @(posedge clock);
    end while (ta !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic t;
    @(posedge clock);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(negedge clock);
      t = s_axi_arready;
      @(posedge clock);
    end while (t !== 1'h1);
    s_axi_arvalid <= 1'h0;
    repeat ($urandom_range(0, 2)) @(posedge clock);
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clock);
      t = s_axi_rvalid;
      @(posedge clock);
    end while (t !== 1'h1);
    s_axi_rready <= 1'h0;
  endtask

  task automatic wait_idle();
    do @(negedge clock); while (sync_busy_flag !== 1'h0);
    repeat (2) @(negedge clock);
    @(posedge clock);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Read results compared in bus order
  always @(negedge clock) begin
    if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
      check("rresp", 32'(RESP_OKAY), 32'(s_axi_rresp));
      if (exp_q.size() == 0) check("unexpected_read", 32'h0, s_axi_rdata);
      else check("rdata", exp_q.pop_front(), s_axi_rdata);
    end
  end

  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(3172));
    repeat (16) @(posedge clock);
    rstn <= 1'h1;
    foreach (addrs[i]) rd(addrs[i], 32'h0);
    check("reset_outputs", 32'({sample_total, sampling_half_periods}), 32'({11'h001, 7'h01}));
    done("reset");
    for (int i = 0; i < 16; i++) begin
      v = {1'h0, 3'($urandom), 4'(i)};
      wr(8'h08, 32'(v), 4'h1);
      rd(8'h08, 32'(v));
      check("sample_total", (i <= 10) ? (32'h1 << i) : 32'h0, 32'(sample_total));
      check("adjust_shift", 32'(v[6:4]), 32'(accumulate_divide_shift));
      v = {1'($urandom), 3'h7, 4'(i)};
      rv = v & 8'h8F;
      wr(8'h04, 32'(v), 4'h1);
      rd(8'h04, 32'(rv));
      check("ref", 32'({v[7], 4'(i), 1'(i <= 4)}),
        32'({ref_buffer_offset_comp, reference_select, reference_select_valid}));
      v = 8'($urandom);
      wr(8'h0C, 32'(v), 4'h1);
      rd(8'h0C, 32'(v & 8'h3F));
      check("half_periods", 32'(v[5:0]) + 32'h1, 32'(sampling_half_periods));
    end
    done("fields");
    wr(8'h10, 32'h0000_FFFF, 4'h1);
    wr(8'h10, 32'h0000_FD00, 4'h2);
    rd(8'h10, 32'h0000_053F);
    wait_idle();
    check("ctrl2_out", 32'({prescaler, resolution_select, gain_offset_correction_on, continuous_conversion,
      result_left_align, differential_input}), 32'h17F);
    done("lanes");
    peripheral_write_guard <= 1'h1;
    wr(8'h04, 32'h0000_0085, 4'hF);
    rd(8'h04, 32'(rv));
    peripheral_write_guard <= 1'h0;
    done("guard");
    wr(8'h00, 32'h02, 4'h1);
    rd(8'h00, 32'h02);
    rd(8'h64, 32'h80);
    check("busy_flag", 32'h1, 32'(sync_busy_flag));
    wait_idle();
    check("enabled", 32'(converter_enabled), 32'h1);
    wr(8'h10, 32'h0, 4'h3);
    rd(8'h10, 32'h0000_053F);
    standby_sleep <= 1'h1;
    repeat (3) @(negedge clock);
    check("halted", 32'(converter_running), 32'h0);
    wr(8'h00, 32'h06, 4'h1);
    repeat (3) @(negedge clock);
    check("running", 32'(converter_running), 32'h1);
    while (converter_tick !== 1'h1) @(negedge clock);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (converter_tick !== 1'h1);
    check("tick_gap", 32'(n), 32'h80);
    @(posedge clock);
    standby_sleep <= 1'h0;
    done("enable");
    wr(8'h00, 32'h01, 4'h1);
    rd(8'h00, 32'h07);
    rd(8'h64, 32'h80);
    wait_idle();
    for (int i = 0; i < 6; i++) rd(addrs[i], 32'h0);
    check("disabled", 32'({converter_enabled, prescaler}), 32'h0);
    done("soft_reset");
    print_verdict();
  end
endmodule
